// ===== design/hpc_pkg.sv
// Shared constants for the downstream port power control block.
// Assumes one 10 MHz core clock and a synchronous, active-high reset.
// How it works
// - After reset use individual port control unless configuration selects ganged mode.
// - Ganged mode comes only from the serial slave or one-time configuration.
// - Ganged: one shared pin switches power and senses over-current for all ports.
// - Ganged: an over-current on the shared pin flags every port at once.
// - Individual: each port has one two-way pin for enable and sense.
// - Power off: drive pin low and switch its pull-up off.
// - Power on: release driver, enable pull-up, pin becomes open drain.
// - While powered, a low sensed on the pin may mean over-current.
// - Filter the sense input so short transients are not faults.
// - Battery charging is enabled per port, any subset.
// - Per port, signal presence of a high-current charging supply on control pins; the code drives chargeEn_q on them in ganged mode only, power or not.
// - Continuous low of programmed width, 0 to 15 ms, default 5 ms, is over-current.
// - Two low groups within a rolling window, default 20 ms, is over-current.
// - Ignore the sense input for a lockout time after power on, default 10 ms.
package hpc_pkg;
	localparam int          NUM_PORTS     = 7;
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          MS_PERIOD_NS  = 1000000;
	localparam int          MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  MIN_WIDTH_RST = 4'h5;
	localparam logic [7:0]  INACTIVE_RST  = 8'h14;
	localparam logic [7:0]  LOCKOUT_RST   = 8'h0a;
	localparam logic        GANG_RST      = 1'b0;
endpackage

// ===== design/hpc_cfg_if.sv
// Filter timing settings and millisecond tick handed from top to each filter.
// Assumes every signal is on the core clock.
`timescale 1ns/100ps
`default_nettype none
interface hpc_cfg_if;
	logic       msTick;   // One-cycle pulse each millisecond
	logic [3:0] minWidth; // Single-pulse width in ms
	logic [7:0] inactive; // Double-pulse window in ms
	logic [7:0] lockout;  // Turn-on lockout in ms
	modport src (output msTick, output minWidth, output inactive, output lockout);
	modport dst (input msTick, input minWidth, input inactive, input lockout);
endinterface
`default_nettype wire

// ===== design/hpc_oc_filter.sv
// Over-current sense filter for one port: lockout, single and double pulse detect.
// Assumes senseLow is already synchronised to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module hpc_oc_filter
(
	input  wire logic ref_clk,  // Core clock
	input  wire logic reset,    // Synchronous reset, active high
	hpc_cfg_if.dst    cfg,      // Timing settings and ms tick
	input  wire logic enable,   // Port power on
	input  wire logic senseLow, // Pin seen low
	output logic      ocDetect  // One-cycle over-current pulse
);
	logic       enPrev_q;
	logic [7:0] lockCnt_q;
	logic [3:0] lowMs_q;
	logic       lowPrev_q;
	logic [7:0] winCnt_q;
	logic       tripped_q;
	logic       ocDetect_q;
	logic       powerRise;
	logic       active;
	logic       lowNow;
	logic       groupStart;
	logic       singleHit;
	logic       doubleHit;

	// Sense is looked at only while powered and out of lockout
	assign powerRise  = enable && !enPrev_q;
	assign active     = enable && !powerRise && (lockCnt_q == 8'h00);
	assign lowNow     = active && senseLow;
	assign groupStart = lowNow && !lowPrev_q;
	assign singleHit  = lowNow && (lowMs_q >= cfg.minWidth);
	assign doubleHit  = groupStart && (winCnt_q != 8'h00);
	assign ocDetect   = ocDetect_q;

	// Lockout timer restarts at every power-on edge
	always_ff @(posedge ref_clk)
	begin
		if (reset || !enable)
			lockCnt_q <= 8'h00;
		else if (powerRise)
			lockCnt_q <= cfg.lockout;
		else if (cfg.msTick && lockCnt_q != 8'h00)
			lockCnt_q <= lockCnt_q - 8'h01;
		enPrev_q <= reset ? 1'b0 : enable;
	end

	// Length of the current low run in whole ms
	always_ff @(posedge ref_clk)
	begin
		if (reset || !lowNow)
			lowMs_q <= 4'h0;
		else if (cfg.msTick && lowMs_q != 4'hf)
			lowMs_q <= lowMs_q + 4'h1;
		lowPrev_q <= reset ? 1'b0 : lowNow;
	end

	// Rolling window opened by the first low group
	always_ff @(posedge ref_clk)
	begin
		if (reset || !active)
			winCnt_q <= 8'h00;
		else if (groupStart && winCnt_q == 8'h00)
			winCnt_q <= cfg.inactive;
		else if (cfg.msTick && winCnt_q != 8'h00)
			winCnt_q <= winCnt_q - 8'h01;
	end

	// One report per powered period
	always_ff @(posedge ref_clk)
	begin
		if (reset || !enable)
		begin
			tripped_q  <= 1'b0;
			ocDetect_q <= 1'b0;
		end
		else
		begin
			ocDetect_q <= (singleHit || doubleHit) && !tripped_q;
			if (singleHit || doubleHit)
				tripped_q <= 1'b1;
		end
	end

	a_lockout_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		(lockCnt_q != 8'h00) |=> !ocDetect_q)
		else $error("over-current reported during lockout");
	a_unpowered_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		!enable |=> !ocDetect_q)
		else $error("over-current reported while unpowered");
	a_double_window: assert property (@(posedge ref_clk) disable iff (reset)
		(groupStart && winCnt_q != 8'h00 && !tripped_q) |=> ocDetect_q)
		else $error("second low group inside window not reported");
	a_transient_filter: assert property (@(posedge ref_clk) disable iff (reset)
		(ocDetect_q && cfg.minWidth != 4'h0 && !$past(doubleHit)) |-> $past(lowMs_q != 4'h0))
		else $error("short low reported as over-current");
	c_single_trip: cover property (@(posedge ref_clk) disable iff (reset) singleHit && !tripped_q);
	c_double_trip: cover property (@(posedge ref_clk) disable iff (reset) doubleHit && !tripped_q);
endmodule
`default_nettype wire

// ===== design/hpc_port_ctl.sv
// Top of the downstream port power control: pin drive, sense, flags, charge indicator.
// Assumes pin inputs are asynchronous and config inputs are on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module hpc_port_ctl
#(
	parameter int NPORT     = hpc_pkg::NUM_PORTS,
	parameter int MS_CYCLES = hpc_pkg::MS_CYCLES
)
(
	input  wire logic             ref_clk,          // Core clock, 10 MHz
	input  wire logic             reset,            // Synchronous reset, active high
	input  wire logic             gangModeCfg,      // Ganged mode from serial slave or OTP
	input  wire logic [NPORT-1:0] chargeEnCfg,      // Per-port charging enable config
	input  wire logic [NPORT-1:0] portPowerOn,      // Per-port power request from hub
	input  wire logic [NPORT-1:0] ocClear,          // Per-port flag clear from hub
	input  wire logic             timingWr,         // Load the three timing values
	input  wire logic [3:0]       minWidthWr,       // Single-pulse width in ms
	input  wire logic [7:0]       inactiveWr,       // Double-pulse window in ms
	input  wire logic [7:0]       lockoutWr,        // Turn-on lockout in ms
	input  wire logic             sharedCtlIn,      // Shared pin level
	output logic                  sharedCtlOut,     // Shared pin drive value
	output logic                  sharedCtlOe,      // Shared pin driver on
	output logic                  sharedPullupEn,   // Shared pin pull-up on
	input  wire logic [NPORT-1:0] portCtlIn,        // Per-port pin levels
	output logic      [NPORT-1:0] portCtlOut,       // Per-port pin drive values
	output logic      [NPORT-1:0] portCtlOe,        // Per-port pin drivers on
	output logic      [NPORT-1:0] portPullupEn,     // Per-port pull-ups on
	output logic      [NPORT-1:0] chargeSupplyInd,  // Charging supply present per port
	output logic      [NPORT-1:0] ocFlag,           // Sticky over-current flags
	output logic                  ocService,        // Some port needs servicing
	output logic                  gangMode          // Latched port control mode
);
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	hpc_cfg_if cfgBus ();

	logic             cfgLoaded_q;
	logic             gangMode_q;
	logic [NPORT-1:0] chargeEn_q;
	logic [3:0]       minWidth_q;
	logic [7:0]       inactive_q;
	logic [7:0]       lockout_q;
	logic [15:0]      msCnt_q;
	logic             msTick_q;
	logic             shMeta_q;
	logic             shSync_q;
	logic [NPORT-1:0] pMeta_q;
	logic [NPORT-1:0] pSync_q;
	logic             gangPower;
	logic [NPORT-1:0] chEnable;
	logic [NPORT-1:0] chSenseLow;
	logic [NPORT-1:0] chDetect;
	logic             sharedCtlOut_q;
	logic             sharedCtlOe_q;
	logic             sharedPullupEn_q;
	logic [NPORT-1:0] portCtlOut_q;
	logic [NPORT-1:0] portCtlOe_q;
	logic [NPORT-1:0] portPullupEn_q;
	logic [NPORT-1:0] chargeSupplyInd_q;
	logic [NPORT-1:0] ocFlag_q;
	logic             ocService_q;

	// Mode and charging set are caught once, on the first edge after reset
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cfgLoaded_q <= 1'b0;
			gangMode_q  <= hpc_pkg::GANG_RST;
			chargeEn_q  <= '0;
		end
		else if (!cfgLoaded_q)
		begin
			cfgLoaded_q <= 1'b1;
			gangMode_q  <= gangModeCfg;
			chargeEn_q  <= chargeEnCfg;
		end
	end

	// Filter timing values, documented defaults after reset
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			minWidth_q <= hpc_pkg::MIN_WIDTH_RST;
			inactive_q <= hpc_pkg::INACTIVE_RST;
			lockout_q  <= hpc_pkg::LOCKOUT_RST;
		end
		else if (timingWr)
		begin
			minWidth_q <= minWidthWr;
			inactive_q <= inactiveWr;
			lockout_q  <= lockoutWr;
		end
	end

	// Millisecond tick divider
	always_ff @(posedge ref_clk)
	begin
		if (reset || msCnt_q == MS_LAST)
			msCnt_q <= 16'h0000;
		else
			msCnt_q <= msCnt_q + 16'h0001;
		msTick_q <= !reset && (msCnt_q == MS_LAST);
	end

	assign cfgBus.msTick   = msTick_q;
	assign cfgBus.minWidth = minWidth_q;
	assign cfgBus.inactive = inactive_q;
	assign cfgBus.lockout  = lockout_q;

	// Two-flop synchronisers on every pin input
	always_ff @(posedge ref_clk)
	begin
		shMeta_q <= sharedCtlIn;
		shSync_q <= shMeta_q;
		pMeta_q  <= portCtlIn;
		pSync_q  <= pMeta_q;
	end

	assign gangPower = |portPowerOn;

	// One filter per port; in ganged mode all see the shared pin
	generate
		for (genvar i = 0; i < NPORT; i++)
		begin : g_port
			assign chEnable[i]   = gangMode_q ? gangPower : portPowerOn[i];
			assign chSenseLow[i] = gangMode_q ? !shSync_q : !pSync_q[i];
			hpc_oc_filter u_filter
			(
				.ref_clk  (ref_clk),
				.reset    (reset),
				.cfg      (cfgBus.dst),
				.enable   (chEnable[i]),
				.senseLow (chSenseLow[i]),
				.ocDetect (chDetect[i])
			);
		end
	endgenerate

	// Pin drive: off drives low without pull-up, on releases with pull-up; in ganged mode port pins drive chargeEn_q
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			sharedCtlOut_q   <= 1'b0;
			sharedCtlOe_q    <= 1'b1;
			sharedPullupEn_q <= 1'b0;
			portCtlOut_q     <= '0;
			portCtlOe_q      <= '1;
			portPullupEn_q   <= '0;
		end
		else
		begin
			sharedCtlOut_q   <= 1'b0;
			sharedCtlOe_q    <= !(gangMode_q && gangPower);
			sharedPullupEn_q <= gangMode_q && gangPower;
			if (gangMode_q)
			begin
				portCtlOut_q   <= chargeEn_q;
				portCtlOe_q    <= '1;
				portPullupEn_q <= '0;
			end
			else
			begin
				portCtlOut_q   <= '0;
				portCtlOe_q    <= ~portPowerOn;
				portPullupEn_q <= portPowerOn;
			end
		end
	end

	// Charging supply indicator per configured, powered port
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			chargeSupplyInd_q <= '0;
		else
			chargeSupplyInd_q <= chargeEn_q & chEnable;
	end

	// Sticky flags, a new detection wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ocFlag_q    <= '0;
			ocService_q <= 1'b0;
		end
		else
		begin
			ocFlag_q    <= (ocFlag_q & ~ocClear) | chDetect;
			ocService_q <= |chDetect;
		end
	end

	assign sharedCtlOut    = sharedCtlOut_q;
	assign sharedCtlOe     = sharedCtlOe_q;
	assign sharedPullupEn  = sharedPullupEn_q;
	assign portCtlOut      = portCtlOut_q;
	assign portCtlOe       = portCtlOe_q;
	assign portPullupEn    = portPullupEn_q;
	assign chargeSupplyInd = chargeSupplyInd_q;
	assign ocFlag          = ocFlag_q;
	assign ocService       = ocService_q;
	assign gangMode        = gangMode_q;

	a_mode_held: assert property (@(posedge ref_clk) disable iff (reset)
		cfgLoaded_q |=> $stable(gangMode_q) && $stable(chargeEn_q))
		else $error("latched mode or charge setting changed");
	a_mode_default: assert property (@(posedge ref_clk)
		reset |=> !gangMode_q)
		else $error("mode not individual after reset");
	a_off_drive_low: assert property (@(posedge ref_clk) disable iff (reset)
		(!gangMode_q && !portPowerOn[0]) |=> portCtlOe[0] && !portCtlOut[0] && !portPullupEn[0])
		else $error("unpowered port pin not driven low");
	a_on_open_drain: assert property (@(posedge ref_clk) disable iff (reset)
		(!gangMode_q && portPowerOn[0]) |=> !portCtlOe[0] && portPullupEn[0])
		else $error("powered port pin not released");
	a_gang_pin: assert property (@(posedge ref_clk) disable iff (reset)
		(gangMode_q && gangPower) |=> !sharedCtlOe && sharedPullupEn)
		else $error("shared pin not released in ganged mode");
	a_gang_all_flags: assert property (@(posedge ref_clk) disable iff (reset)
		(gangMode_q && chDetect[0]) |=> &ocFlag_q)
		else $error("ganged over-current did not flag all ports");
	a_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		(ocFlag_q[0] && !ocClear[0]) |=> ocFlag_q[0] [*1] ##0 ocFlag[0])
		else $error("over-current flag dropped without clear");
	a_service_req: assert property (@(posedge ref_clk) disable iff (reset)
		chDetect[0] |=> ocService && ocFlag[0])
		else $error("detection did not request service");
	a_charge_ind: assert property (@(posedge ref_clk) disable iff (reset)
		!chargeEn_q[0] |=> !chargeSupplyInd[0])
		else $error("charge indicator on an unconfigured port");
	c_gang_trip: cover property (@(posedge ref_clk) disable iff (reset) gangMode_q && chDetect[0]);
	c_indiv_trip: cover property (@(posedge ref_clk) disable iff (reset) !gangMode_q && chDetect[0]);
	c_clear_flag: cover property (@(posedge ref_clk) disable iff (reset) ocFlag_q[0] && ocClear[0]);
endmodule
`default_nettype wire

// ===== dv/hpc_switch_model.sv
// External power switches with open-drain fault outputs, one per pin.
// Assumes bit N-1 is the shared pin and the bench raises fault only on powered pins.
`timescale 1ns/100ps
`default_nettype none
module hpc_switch_model
#(
	parameter int N = 8
)
(
	input  wire logic         ref_clk, // Core clock, paces the floating pattern
	input  wire logic [N-1:0] oe,      // Device driving the pin
	input  wire logic [N-1:0] out,     // Device drive value
	input  wire logic [N-1:0] pullEn,  // Device pull-up on
	input  wire logic [N-1:0] fault,   // Over-current request from bench
	output logic      [N-1:0] level    // Resolved pin level
);
	logic toggle_q;

	// A pin with no driver and no pull-up wanders every cycle
	initial toggle_q = 1'b0;
	always @(posedge ref_clk)
	begin
		toggle_q <= ~toggle_q;
	end

	// Fault output pulls the line low wherever the device has released it
	assign level = (oe & out) | (~oe & ~fault & (pullEn | {N{toggle_q}}));
endmodule
`default_nettype wire

// ===== dv/hpc_port_ctl_tb.sv
// Self-checking bench for the port power control top with switch models on every pin.
// Assumes a shortened millisecond of 20 core cycles.
`timescale 1ns/100ps
`default_nettype none
module hpc_port_ctl_tb;
	localparam int NP = hpc_pkg::NUM_PORTS;
	logic          ref_clk, reset, gangModeCfg, timingWr;
	logic [NP-1:0] chargeEnCfg, portPowerOn, ocClear;
	logic [3:0]    minWidthWr;
	logic [7:0]    inactiveWr, lockoutWr;
	logic          sharedCtlOut, sharedCtlOe, sharedPullupEn, ocService, gangMode;
	logic [NP-1:0] portCtlOut, portCtlOe, portPullupEn, chargeSupplyInd, ocFlag;
	logic [NP:0]   pinLevel, fault;
	int            err_count, total_checks, cycles, svcCount, s;

	hpc_port_ctl #(.NPORT(NP), .MS_CYCLES(20)) dut (.ref_clk(ref_clk), .reset(reset),
		.gangModeCfg(gangModeCfg), .chargeEnCfg(chargeEnCfg), .portPowerOn(portPowerOn),
		.ocClear(ocClear), .timingWr(timingWr), .minWidthWr(minWidthWr),
		.inactiveWr(inactiveWr), .lockoutWr(lockoutWr), .sharedCtlIn(pinLevel[NP]),
		.sharedCtlOut(sharedCtlOut), .sharedCtlOe(sharedCtlOe),
		.sharedPullupEn(sharedPullupEn), .portCtlIn(pinLevel[NP-1:0]),
		.portCtlOut(portCtlOut), .portCtlOe(portCtlOe), .portPullupEn(portPullupEn),
		.chargeSupplyInd(chargeSupplyInd), .ocFlag(ocFlag), .ocService(ocService),
		.gangMode(gangMode));

	hpc_switch_model #(.N(NP+1)) sw (.ref_clk(ref_clk), .oe({sharedCtlOe, portCtlOe}),
		.out({sharedCtlOut, portCtlOut}), .pullEn({sharedPullupEn, portPullupEn}),
		.fault(fault), .level(pinLevel));

	// Clock at 10 MHz
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Cycle count, service pulse count and hang limit
	always @(posedge ref_clk)
	begin
		cycles++;
		if (ocService === 1'b1)
			svcCount++;
		if (cycles == 10000)
		begin
			err_count++;
			wrap_up();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic chk(input string name, input logic [NP-1:0] exp, input logic [NP-1:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// Reset with a mode request, then change config to show it is latched
	task automatic doReset(input logic g);
		gangModeCfg = g;
		chargeEnCfg = 7'h05;
		reset = 1'b1;
		cyc(10);
		reset = 1'b0;
		cyc(3);
		gangModeCfg = ~g;
		chargeEnCfg = 7'h7a;
	endtask

	task automatic setTiming(input logic [3:0] w, input logic [7:0] win, input logic [7:0] lk);
		minWidthWr = w;
		inactiveWr = win;
		lockoutWr = lk;
		timingWr = 1'b1;
		cyc(1);
		timingWr = 1'b0;
	endtask

	task automatic pulseLow(input int idx, input int n);
		fault[idx] = 1'b1;
		cyc(n);
		fault[idx] = 1'b0;
	endtask

	task automatic waitFlag(input logic [NP-1:0] exp, input int n);
		for (int i = 0; i < n && ocFlag !== exp; i++)
			cyc(1);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{reset, gangModeCfg, timingWr, minWidthWr, inactiveWr, lockoutWr} = '0;
		{chargeEnCfg, portPowerOn, ocClear, fault} = '0;
		{err_count, total_checks, cycles, svcCount} = '0;
		reset = 1'b1;
		@(negedge ref_clk);
		doReset(1'b0);
		chk("gangMode", 7'h00, 7'(gangMode));
		chk("portCtlOe", 7'h7f, portCtlOe);
		chk("portCtlOut", 7'h00, portCtlOut);
		chk("portPullupEn", 7'h00, portPullupEn);
		// Lockout then immediate detection, sticky flag and clear
		setTiming(4'h0, 8'h01, 8'h0a);
		portPowerOn = 7'h01;
		cyc(2);
		chk("portCtlOe", 7'h7e, portCtlOe);
		chk("portPullupEn", 7'h01, portPullupEn);
		chk("chargeSupplyInd", 7'h01, chargeSupplyInd);
		cyc(20);
		pulseLow(0, 40);
		cyc(2);
		chk("ocFlag", 7'h00, ocFlag);
		cyc(190);
		s = svcCount;
		pulseLow(0, 10);
		waitFlag(7'h01, 10);
		chk("ocFlag", 7'h01, ocFlag);
		chk("ocService", 7'(s + 1), 7'(svcCount));
		cyc(20);
		chk("ocFlag", 7'h01, ocFlag);
		ocClear = 7'h01;
		cyc(1);
		ocClear = 7'h00;
		cyc(1);
		chk("ocFlag", 7'h00, ocFlag);
		portPowerOn = 7'h00;
		cyc(2);
		chk("portCtlOe", 7'h7f, portCtlOe);
		chk("portPullupEn", 7'h00, portPullupEn);
		// Single pulse: short low filtered, long low detected
		setTiming(4'h2, 8'h01, 8'h01);
		portPowerOn = 7'h02;
		cyc(60);
		chk("chargeSupplyInd", 7'h00, chargeSupplyInd);
		pulseLow(1, 12);
		cyc(60);
		chk("ocFlag", 7'h00, ocFlag);
		pulseLow(1, 100);
		waitFlag(7'h02, 40);
		chk("ocFlag", 7'h02, ocFlag);
		// Double pulse inside the rolling window
		portPowerOn = 7'h00;
		ocClear = 7'h7f;
		cyc(1);
		ocClear = 7'h00;
		setTiming(4'h5, 8'h14, 8'h01);
		portPowerOn = 7'h02;
		cyc(60);
		pulseLow(1, 5);
		cyc(5);
		chk("ocFlag", 7'h00, ocFlag);
		cyc(35);
		pulseLow(1, 5);
		waitFlag(7'h02, 10);
		chk("ocFlag", 7'h02, ocFlag);
		// Ganged mode with default timing on the shared pin
		portPowerOn = 7'h00;
		doReset(1'b1);
		chk("gangMode", 7'h01, 7'(gangMode));
		chk("sharedCtlOe", 7'h01, 7'(sharedCtlOe));
		chk("sharedCtlOut", 7'h00, 7'(sharedCtlOut));
		chk("sharedPullupEn", 7'h00, 7'(sharedPullupEn));
		chk("portCtlOut", 7'h05, portCtlOut);
		portPowerOn = 7'h04;
		cyc(2);
		chk("sharedCtlOe", 7'h00, 7'(sharedCtlOe));
		chk("sharedPullupEn", 7'h01, 7'(sharedPullupEn));
		chk("portCtlOe", 7'h7f, portCtlOe);
		chk("chargeSupplyInd", 7'h05, chargeSupplyInd);
		cyc(220);
		pulseLow(NP, 160);
		waitFlag(7'h7f, 40);
		chk("ocFlag", 7'h7f, ocFlag);
		wrap_up();
	end
endmodule
`default_nettype wire
